// File: hdl/hpr_map.svh
// Register offsets, field positions, reset values and limits of the ratio block.
// Included by the core; holds definitions only.
`ifndef HPR_MAP_SVH
`define HPR_MAP_SVH

`define HPR_OFF_CTRL 8'h00
`define HPR_OFF_OFFSET 8'h04
`define HPR_OFF_THRESH 8'h08
`define HPR_OFF_AVGDAYS 8'h0C
`define HPR_OFF_PULSECNT 8'h10
`define HPR_OFF_RATIO 8'h14
`define HPR_OFF_HEAT 8'h18
`define HPR_OFF_COOL 8'h1C
`define HPR_OFF_STATUS 8'h20
`define HPR_OFF_PRESET 8'h24
`define HPR_OFF_TEMPS 8'h28

`define HPR_CTRL_TYPE_LSB 0
`define HPR_CTRL_OFSEN_BIT 8
`define HPR_CTRL_PRESET_LSB 16
`define HPR_CTRL_HUNIT_LSB 24
`define HPR_CTRL_PSCALE_LSB 28

`define HPR_TYPE_HEAT 4'h2
`define HPR_TYPE_HCNOTHR 4'h3
`define HPR_TYPE_COOL 4'h5
`define HPR_TYPE_HCTHR 4'h6

`define HPR_RST_TYPE 4'h2
`define HPR_RST_AVGDAYS 5'h07
`define HPR_RST_THRESH 16'h61A8
`define HPR_THR_OFF 16'h61A8
`define HPR_THR_MIN 16'h0001
`define HPR_THR_MAX 16'h4650
`define HPR_DAYS_MIN 5'h05
`define HPR_DAYS_MAX 5'h1E
`define HPR_OFS_MAX 8'h63
`define HPR_OFS_MIN 8'h9D
`define HPR_RATIO_MAX 8'hC7
`define HPR_RATIO_TEN 4'hA

`endif

// File: hdl/hpr_pkg.sv
// Types shared by the ratio block.
// Used by the core only.
package hpr_pkg;
  localparam int HPR_DAYS = 30;
  typedef enum logic [1:0] {
    HPR_IDLE,
    HPR_DIV
  } hpr_state_t;
  typedef enum logic [1:0] {
    HPR_SEL_CUR,
    HPR_SEL_MON,
    HPR_SEL_YEAR
  } hpr_sel_t;
  typedef logic [47:0] hpr_energy_t;
endpackage : hpr_pkg

// File: hdl/hpr_core.sv
// Heat pump performance ratio, sensor offset and heat/cooling selection.
// Assumes day, month and year ticks and volume strobes come from logic on ref_clk;
// the auxiliary pulse arrives from a pin and is synchronised here.
`timescale 1ns/1ps
`include "hpr_map.svh"
module hpr_core
  import hpr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic auxPulseEnergyInput,
  input wire logic [15:0] inletTempRaw,
  input wire logic [15:0] outletTempRaw,
  input wire logic [15:0] temp3Raw,
  input wire logic [15:0] temp4Raw,
  input wire logic [3:0] sensorErr,
  input wire logic volStrobe,
  input wire logic [15:0] volInc,
  input wire logic dayTick,
  input wire logic monthTick,
  input wire logic yearTick,
  output logic [7:0] perfRatio,
  output logic [7:0] monthPerfRatio,
  output logic [7:0] seasonalPerfRatio,
  output logic [47:0] heatEnergyTotal,
  output logic [47:0] coolingEnergyTotal
);

  // ==========================================================
  // Register bus
  logic [3:0] meterType;
  logic offsetEnable;
  logic [3:0] presetSel;
  logic [1:0] flowResolutionSelect;
  logic [1:0] pulseInputScaleSelect;
  logic [7:0] sensorOffsetValue;
  logic [15:0] heatCoolChangeoverLimit;
  logic [4:0] avgDays;
  logic [31:0] auxCount;
  logic [15:0] presetTemp;
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] rdData;
  logic rdHit;
  logic [31:0] ctrlWord;

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire [31:0] wMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  wire wrCtrl = doWrite && (awAddr == `HPR_OFF_CTRL);
  wire wrOffset = doWrite && (awAddr == `HPR_OFF_OFFSET);
  wire wrThresh = doWrite && (awAddr == `HPR_OFF_THRESH);
  wire wrDays = doWrite && (awAddr == `HPR_OFF_AVGDAYS);
  wire wrPulse = doWrite && (awAddr == `HPR_OFF_PULSECNT);
  wire wrPreset = doWrite && (awAddr == `HPR_OFF_PRESET);
  wire wrHit = wrCtrl || wrOffset || wrThresh || wrDays || wrPulse || wrPreset;
  wire [31:0] newCtrl = (ctrlWord & ~wMask) | (wData & wMask);
  wire [31:0] newOfs = ({24'h000000, sensorOffsetValue} & ~wMask) | (wData & wMask);
  wire [31:0] newThr = ({16'h0000, heatCoolChangeoverLimit} & ~wMask) | (wData & wMask);
  wire [31:0] newDays = ({27'h0000000, avgDays} & ~wMask) | (wData & wMask);
  wire [31:0] newPulse = (auxCount & ~wMask) | (wData & wMask);
  wire [31:0] newPreset = ({16'h0000, presetTemp} & ~wMask) | (wData & wMask);
  wire [3:0] newType = newCtrl[`HPR_CTRL_TYPE_LSB +: 4];
  wire typeOk = (newType == `HPR_TYPE_HEAT) || (newType == `HPR_TYPE_HCNOTHR) ||
                (newType == `HPR_TYPE_COOL) || (newType == `HPR_TYPE_HCTHR);
  wire signed [7:0] newOfsS = newOfs[7:0];
  wire ofsOk = (newOfsS <= $signed(`HPR_OFS_MAX)) && (newOfsS >= $signed(`HPR_OFS_MIN));
  wire thrOk = (newThr[15:0] == `HPR_THR_OFF) ||
               (newThr[15:0] >= `HPR_THR_MIN && newThr[15:0] <= `HPR_THR_MAX);
  wire daysOk = (newDays[4:0] >= `HPR_DAYS_MIN) && (newDays[4:0] <= `HPR_DAYS_MAX);
  // Any change of unit, resolution or pulse preset wipes the ratio history
  wire cfgChange = (wrCtrl && (newCtrl[`HPR_CTRL_HUNIT_LSB +: 2] != flowResolutionSelect ||
                    newCtrl[`HPR_CTRL_PSCALE_LSB +: 2] != pulseInputScaleSelect)) ||
                   wrPulse;
  wire thrEnabled = (meterType == `HPR_TYPE_HCTHR) &&
                    (heatCoolChangeoverLimit != `HPR_THR_OFF);

  assign ctrlWord = {2'b00, pulseInputScaleSelect, 2'b00, flowResolutionSelect, 4'h0,
                     presetSel, 7'h00, offsetEnable, 4'h0, meterType};
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration registers; illegal values are dropped, not clipped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meterType <= `HPR_RST_TYPE;
      offsetEnable <= 1'b0;
      presetSel <= 4'h0;
      flowResolutionSelect <= 2'b00;
      pulseInputScaleSelect <= 2'b00;
      sensorOffsetValue <= 8'h00;
      heatCoolChangeoverLimit <= `HPR_RST_THRESH;
      avgDays <= `HPR_RST_AVGDAYS;
      presetTemp <= 16'h0000;
    end else if (clkEn) begin
      if (wrCtrl) begin
        if (typeOk) begin
          meterType <= newType;
        end
        offsetEnable <= newCtrl[`HPR_CTRL_OFSEN_BIT];
        presetSel <= newCtrl[`HPR_CTRL_PRESET_LSB +: 4];
        flowResolutionSelect <= newCtrl[`HPR_CTRL_HUNIT_LSB +: 2];
        pulseInputScaleSelect <= newCtrl[`HPR_CTRL_PSCALE_LSB +: 2];
        if (typeOk && newType != `HPR_TYPE_HCTHR) begin
          heatCoolChangeoverLimit <= `HPR_THR_OFF;
        end
      end
      if (wrOffset && ofsOk) begin
        sensorOffsetValue <= newOfs[7:0];
      end
      if (wrThresh && thrOk && meterType == `HPR_TYPE_HCTHR) begin
        heatCoolChangeoverLimit <= newThr[15:0];
      end
      if (wrDays && daysOk) begin
        avgDays <= newDays[4:0];
      end
      if (wrPreset) begin
        presetTemp <= newPreset[15:0];
      end
    end
  end

  // ==========================================================
  // Temperature offset per channel
  logic [15:0] tempRaw [4];
  logic [15:0] tempCorr [4];
  assign tempRaw[0] = inletTempRaw;
  assign tempRaw[1] = outletTempRaw;
  assign tempRaw[2] = temp3Raw;
  assign tempRaw[3] = temp4Raw;
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : gOffset
      // A zero offset adds zero, so no separate bypass is needed
      wire [15:0] ofsExt = offsetEnable ? {{8{sensorOffsetValue[7]}}, sensorOffsetValue}
                                        : 16'h0000;
      assign tempCorr[ch] = presetSel[ch] ? presetTemp : tempRaw[ch] + ofsExt;
    end
  endgenerate

  // ==========================================================
  // Heat / cooling selection and accumulation
  wire signed [15:0] tIn = tempCorr[0];
  wire signed [15:0] tOut = tempCorr[1];
  wire signed [16:0] dT = {tIn[15], tIn} - {tOut[15], tOut};
  wire [15:0] absDT = dT[16] ? 16'(-dT) : dT[15:0];
  wire [31:0] eInc = volInc * absDT;
  wire heatType = (meterType == `HPR_TYPE_HEAT) || (meterType == `HPR_TYPE_HCNOTHR) ||
                  (meterType == `HPR_TYPE_HCTHR);
  wire coolType = (meterType == `HPR_TYPE_COOL) || (meterType == `HPR_TYPE_HCNOTHR) ||
                  (meterType == `HPR_TYPE_HCTHR);
  wire aboveThr = tIn >= $signed(heatCoolChangeoverLimit);
  wire pairOk = !sensorErr[0] && !sensorErr[1];
  wire doHeat = volStrobe && pairOk && heatType && (dT > 0) && (!thrEnabled || aboveThr);
  wire doCool = volStrobe && pairOk && coolType && (dT < 0) && (!thrEnabled || !aboveThr);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      heatEnergyTotal <= 48'h000000000000;
      coolingEnergyTotal <= 48'h000000000000;
    end else if (clkEn) begin
      if (doHeat) begin
        heatEnergyTotal <= heatEnergyTotal + {16'h0000, eInc};
      end
      if (doCool) begin
        coolingEnergyTotal <= coolingEnergyTotal + {16'h0000, eInc};
      end
    end
  end

  // ==========================================================
  // Auxiliary pulse input: three stages, second and third must agree
  logic pSync1, pSync2, pSync3, pulseLvl;
  wire pulseRise = (pSync2 == pSync3) && pSync3 && !pulseLvl;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pSync1 <= 1'b0;
      pSync2 <= 1'b0;
      pSync3 <= 1'b0;
      pulseLvl <= 1'b0;
      auxCount <= 32'h00000000;
    end else if (clkEn) begin
      pSync1 <= auxPulseEnergyInput;
      pSync2 <= pSync1;
      pSync3 <= pSync2;
      if (pSync2 == pSync3) begin
        pulseLvl <= pSync3;
      end
      if (wrPulse) begin
        auxCount <= newPulse;
      end else if (pulseRise) begin
        auxCount <= auxCount + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Daily logging and moving window
  logic [31:0] dayHeat;
  logic [15:0] dayPulses;
  logic dayOk, partialDay;
  logic [5:0] logCount;
  hpr_energy_t winHeat [HPR_DAYS];
  hpr_energy_t winElec [HPR_DAYS];
  logic [HPR_DAYS-1:0] winValid;
  hpr_energy_t sumHeat [HPR_DAYS+1];
  hpr_energy_t sumElec [HPR_DAYS+1];
  logic [HPR_DAYS:0] allValid;
  hpr_energy_t monHeat, monElec, yrHeat, yrElec;
  // Totals of the period just closed; the running sums restart at the tick
  hpr_energy_t monSnapH, monSnapE, yrSnapH, yrSnapE;

  // Scale both energies to a common base before they meet in the divider
  wire [9:0] heatScale = (flowResolutionSelect == 2'b00) ? 10'h001 :
                         (flowResolutionSelect == 2'b01) ? 10'h00A :
                         (flowResolutionSelect == 2'b10) ? 10'h064 : 10'h3E8;
  wire [9:0] pulseScale = (pulseInputScaleSelect == 2'b00) ? 10'h001 :
                          (pulseInputScaleSelect == 2'b01) ? 10'h00A :
                          (pulseInputScaleSelect == 2'b10) ? 10'h064 : 10'h3E8;
  wire [47:0] dayHeatScaled = 48'(dayHeat) * 48'(heatScale);
  wire [47:0] dayElecScaled = 48'(dayPulses) * 48'(pulseScale);
  wire dayValid = dayOk && !partialDay;

  assign sumHeat[0] = 48'h000000000000;
  assign sumElec[0] = 48'h000000000000;
  assign allValid[0] = 1'b1;
  genvar d;
  generate
    for (d = 0; d < HPR_DAYS; d++) begin : gWindow
      wire inWin = d < avgDays;
      assign sumHeat[d+1] = sumHeat[d] + (inWin ? winHeat[d] : 48'h000000000000);
      assign sumElec[d+1] = sumElec[d] + (inWin ? winElec[d] : 48'h000000000000);
      assign allValid[d+1] = allValid[d] && (!inWin || winValid[d]);
      always_ff @(posedge ref_clk) begin
        if (srst || (clkEn && cfgChange)) begin
          winHeat[d] <= 48'h000000000000;
          winElec[d] <= 48'h000000000000;
          winValid[d] <= 1'b0;
        end else if (clkEn && dayTick) begin
          winHeat[d] <= (d == 0) ? dayHeatScaled : winHeat[(d == 0) ? 0 : d-1];
          winElec[d] <= (d == 0) ? dayElecScaled : winElec[(d == 0) ? 0 : d-1];
          winValid[d] <= (d == 0) ? dayValid : winValid[(d == 0) ? 0 : d-1];
        end
      end
    end
  endgenerate

  // Window is trusted only once avgDays+1 loggings passed since clearing
  wire winReady = (logCount > {1'b0, avgDays}) && allValid[HPR_DAYS];

  always_ff @(posedge ref_clk) begin
    if (srst || (clkEn && cfgChange)) begin
      dayHeat <= 32'h00000000;
      dayPulses <= 16'h0000;
      dayOk <= 1'b1;
      partialDay <= 1'b1;
      logCount <= 6'h00;
      monHeat <= 48'h000000000000;
      monElec <= 48'h000000000000;
      yrHeat <= 48'h000000000000;
      yrElec <= 48'h000000000000;
    end else if (clkEn) begin
      if (dayTick) begin
        dayHeat <= doHeat ? eInc : 32'h00000000;
        dayPulses <= pulseRise ? 16'h0001 : 16'h0000;
        dayOk <= pairOk;
        partialDay <= 1'b0;
        if (logCount != 6'h3F) begin
          logCount <= logCount + 6'h01;
        end
        monHeat <= monthTick ? 48'h000000000000 : monHeat + dayHeatScaled;
        monElec <= monthTick ? 48'h000000000000 : monElec + dayElecScaled;
        yrHeat <= yearTick ? 48'h000000000000 : yrHeat + dayHeatScaled;
        yrElec <= yearTick ? 48'h000000000000 : yrElec + dayElecScaled;
        if (monthTick) begin
          monSnapH <= monHeat;
          monSnapE <= monElec;
        end
        if (yearTick) begin
          yrSnapH <= yrHeat;
          yrSnapE <= yrElec;
        end
      end else begin
        if (doHeat) begin
          dayHeat <= dayHeat + eInc;
        end
        if (pulseRise) begin
          dayPulses <= dayPulses + 16'h0001;
        end
        if (!pairOk) begin
          dayOk <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Shared divider: quotient in tenths by repeated subtraction
  hpr_state_t state;
  hpr_sel_t sel;
  logic pendCur, pendMon, pendYear;
  logic [51:0] rem;
  logic [47:0] den;
  logic [7:0] quo;
  wire startCur = pendCur && state == HPR_IDLE;
  wire startMon = pendMon && !pendCur && state == HPR_IDLE;
  wire startYear = pendYear && !pendCur && !pendMon && state == HPR_IDLE;
  wire [51:0] numCur = 52'(sumHeat[HPR_DAYS]) * 52'(`HPR_RATIO_TEN);
  wire [51:0] numMon = 52'(monSnapH) * 52'(`HPR_RATIO_TEN);
  wire [51:0] numYear = 52'(yrSnapH) * 52'(`HPR_RATIO_TEN);
  wire divDone = (rem < {4'h0, den}) || (quo == `HPR_RATIO_MAX);

  always_ff @(posedge ref_clk) begin
    if (srst || (clkEn && cfgChange)) begin
      state <= HPR_IDLE;
      sel <= HPR_SEL_CUR;
      pendCur <= 1'b0;
      pendMon <= 1'b0;
      pendYear <= 1'b0;
      rem <= 52'h0000000000000;
      den <= 48'h000000000000;
      quo <= 8'h00;
      perfRatio <= 8'h00;
      monthPerfRatio <= 8'h00;
      seasonalPerfRatio <= 8'h00;
    end else if (clkEn) begin
      // Month and year snapshots are taken before today's logging is added
      if (dayTick) begin
        pendCur <= 1'b1;
      end else if (startCur) begin
        pendCur <= 1'b0;
      end
      if (monthTick) begin
        pendMon <= 1'b1;
      end else if (startMon) begin
        pendMon <= 1'b0;
      end
      if (yearTick) begin
        pendYear <= 1'b1;
      end else if (startYear) begin
        pendYear <= 1'b0;
      end
      unique case (state)
        HPR_IDLE: begin
          quo <= 8'h00;
          if (startCur) begin
            sel <= HPR_SEL_CUR;
            rem <= numCur;
            den <= sumElec[HPR_DAYS];
            if (!winReady || sumElec[HPR_DAYS] == 48'h000000000000) begin
              perfRatio <= 8'h00;
            end else begin
              state <= HPR_DIV;
            end
          end else if (startMon) begin
            sel <= HPR_SEL_MON;
            rem <= numMon;
            den <= monSnapE;
            if (monSnapE == 48'h000000000000) begin
              monthPerfRatio <= 8'h00;
            end else begin
              state <= HPR_DIV;
            end
          end else if (startYear) begin
            sel <= HPR_SEL_YEAR;
            rem <= numYear;
            den <= yrSnapE;
            if (yrSnapE == 48'h000000000000) begin
              seasonalPerfRatio <= 8'h00;
            end else begin
              state <= HPR_DIV;
            end
          end
        end
        HPR_DIV: begin
          if (divDone) begin
            state <= HPR_IDLE;
            unique case (sel)
              HPR_SEL_CUR: perfRatio <= quo;
              HPR_SEL_MON: monthPerfRatio <= quo;
              default: seasonalPerfRatio <= quo;
            endcase
          end else begin
            rem <= rem - {4'h0, den};
            quo <= quo + 8'h01;
          end
        end
        default: state <= HPR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read decode
  wire [7:0] ofsRead = offsetEnable ? sensorOffsetValue : 8'h00;
  wire [31:0] statusWord = {19'h00000, logCount[4:0], 5'h00, thrEnabled, winReady,
                            !offsetEnable};
  assign rdHit = (s_axi_araddr <= `HPR_OFF_TEMPS) && (s_axi_araddr[1:0] == 2'b00);
  assign rdData =
    (s_axi_araddr == `HPR_OFF_CTRL) ? ctrlWord :
    (s_axi_araddr == `HPR_OFF_OFFSET) ? {24'h000000, ofsRead} :
    (s_axi_araddr == `HPR_OFF_THRESH) ? {16'h0000, heatCoolChangeoverLimit} :
    (s_axi_araddr == `HPR_OFF_AVGDAYS) ? {27'h0000000, avgDays} :
    (s_axi_araddr == `HPR_OFF_PULSECNT) ? auxCount :
    (s_axi_araddr == `HPR_OFF_RATIO) ? {8'h00, seasonalPerfRatio, monthPerfRatio, perfRatio} :
    (s_axi_araddr == `HPR_OFF_HEAT) ? heatEnergyTotal[31:0] :
    (s_axi_araddr == `HPR_OFF_COOL) ? coolingEnergyTotal[31:0] :
    (s_axi_araddr == `HPR_OFF_STATUS) ? statusWord :
    (s_axi_araddr == `HPR_OFF_PRESET) ? {16'h0000, presetTemp} :
    (s_axi_araddr == `HPR_OFF_TEMPS) ? {tempCorr[1], tempCorr[0]} : 32'h00000000;

endmodule : hpr_core

// File: verif/hpr_core_monitor.sv
// Port-level checks for the ratio core.
// Assumes bind onto hpr_core; one clock, srst sync high.
`timescale 1ns/1ps
// ====
// Checks
module hpr_core_monitor (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] sensorErr,
  input wire logic [7:0] perfRatio,
  input wire logic [7:0] monthPerfRatio,
  input wire logic [7:0] seasonalPerfRatio,
  input wire logic [47:0] heatEnergyTotal
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence cntWrite;
    clkEn && s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h10;
  endsequence
  // Four cycles so a strobe already in flight has landed
  sequence errHeld;
    (sensorErr[1:0] != 2'h0)[*4];
  endsequence
  ratio_range_a: assert property (perfRatio <= 8'hC7) else $error("ratio range");
  period_range_a: assert property (monthPerfRatio <= 8'hC7 && seasonalPerfRatio <= 8'hC7)
    else $error("period ratio range");
  ratio_clear_a: assert property (cntWrite |-> ##[1:4] perfRatio == 8'h00)
    else $error("ratio not cleared");
  heat_grow_a: assert property (heatEnergyTotal >= $past(heatEnergyTotal))
    else $error("heat total fell");
  heat_stall_a: assert property (errHeld |-> $stable(heatEnergyTotal))
    else $error("heat counted on error");
  freeze_hold_a: assert property (!clkEn |=> $stable(heatEnergyTotal) && $stable(perfRatio))
    else $error("state moved while frozen");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  reset_zero_a: assert property ($fell(srst) |-> perfRatio == 8'h00 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  resp_retire_a: assert property (clkEn && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
endmodule : hpr_core_monitor
bind hpr_core hpr_core_monitor mon (.ref_clk, .srst, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .sensorErr, .perfRatio,
  .monthPerfRatio, .seasonalPerfRatio, .heatEnergyTotal);

// File: verif/hpr_meter_model.sv
// Electricity meter pulse output feeding the aux input.
// Assumes the bench calls send; idle level is low.
`timescale 1ns/1ps
// ====
// Model
module hpr_meter_model (
  input wire logic ref_clk,
  output logic pulseOut
);
  initial pulseOut = 1'h0;
  // Six cycles each way so the three-flop sync never misses one
  task automatic send(input int n);
    repeat (n) begin
      pulseOut <= 1'h1;
      repeat (6) @(posedge ref_clk);
      pulseOut <= 1'h0;
      repeat (6) @(posedge ref_clk);
    end
  endtask : send
endmodule : hpr_meter_model

// File: verif/tb_top.sv
// Directed bench for the ratio core over AXI4-Lite.
// Assumes core, monitor and meter model compiled first.
`timescale 1ns/1ps
// ====
// Bench
module tb_top;
  logic ref_clk = 1'h0, srst = 1'h1, clkEn = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, volStrobe = 1'h0, dayTick = 1'h0, monthTick = 1'h0, yearTick = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, auxPulseEnergyInput;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, perfRatio, monthPerfRatio;
  logic [7:0] seasonalPerfRatio;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [15:0] inletTempRaw = 16'h0, outletTempRaw = 16'h0, volInc = 16'h0;
  logic [15:0] temp3Raw = 16'h0, temp4Raw = 16'h0;
  logic [3:0] s_axi_wstrb = 4'hF, sensorErr = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [47:0] heatEnergyTotal, coolingEnergyTotal;
  int badCount = 0, nCompared = 0;
  initial forever #20 ref_clk = ~ref_clk;
  hpr_meter_model meter (.ref_clk, .pulseOut(auxPulseEnergyInput));
  hpr_core uut (.ref_clk, .srst, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .auxPulseEnergyInput, .inletTempRaw, .outletTempRaw,
    .temp3Raw, .temp4Raw, .sensorErr, .volStrobe, .volInc, .dayTick, .monthTick, .yearTick,
    .perfRatio, .monthPerfRatio, .seasonalPerfRatio, .heatEnergyTotal, .coolingEnergyTotal);
  task automatic giveVerdict();
    if (badCount == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : giveVerdict
  task automatic check(input logic [95:0] seen, input logic [95:0] want);
    nCompared++;
    if (seen !== want) begin
      badCount++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask : check
  task automatic waitEnd(input int i);
    if (i == 40) begin
      badCount++;
      giveVerdict();
    end
  endtask : waitEnd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    waitEnd(i);
    check(s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    waitEnd(i);
    check({s_axi_rresp, s_axi_rdata}, {2'h0, d});
  endtask : rd
  task automatic flow(input logic [15:0] n);
    volStrobe <= 1'h1;
    volInc <= n;
    @(posedge ref_clk);
    volStrobe <= 1'h0;
    repeat (7) @(posedge ref_clk);
  endtask : flow
  // One logged day: a flow, p meter pulses, then the day tick and time for the divider
  task automatic day(input int p, input logic last);
    flow(16'h2);
    meter.send(p);
    dayTick <= 1'h1;
    monthTick <= last;
    yearTick <= last;
    @(posedge ref_clk);
    dayTick <= 1'h0;
    monthTick <= 1'h0;
    yearTick <= 1'h0;
    repeat (250) @(posedge ref_clk);
  endtask : day
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    rd(8'h00, 32'h2);
    rd(8'h0C, 32'h7);
    rd(8'h08, 32'h61A8);
    rd(8'h20, 32'h1);
    wr(8'h40, 32'h1, 2'h2);
    wr(8'h08, 32'hBB8, 2'h0);
    rd(8'h08, 32'h61A8);
    wr(8'h0C, 32'h4, 2'h0);
    rd(8'h0C, 32'h7);
    wr(8'h00, 32'h6, 2'h0);
    wr(8'h08, 32'hBB8, 2'h0);
    rd(8'h20, 32'h5);
    // Inlet below the limit, then exactly on it
    inletTempRaw <= 16'h9C4;
    outletTempRaw <= 16'h7D0;
    flow(16'h2);
    check(heatEnergyTotal, 48'h0);
    inletTempRaw <= 16'hBB8;
    flow(16'h2);
    check(heatEnergyTotal, 48'h7D0);
    wr(8'h00, 32'h3, 2'h0);
    inletTempRaw <= 16'h7D0;
    outletTempRaw <= 16'h9C4;
    flow(16'h2);
    check(coolingEnergyTotal, 48'h3E8);
    outletTempRaw <= 16'h7D0;
    flow(16'h2);
    check({heatEnergyTotal, coolingEnergyTotal}, {48'h7D0, 48'h3E8});
    sensorErr <= 4'h1;
    outletTempRaw <= 16'h9C4;
    flow(16'h2);
    check(coolingEnergyTotal, 48'h3E8);
    sensorErr <= 4'h0;
    wr(8'h00, 32'h2, 2'h0);
    inletTempRaw <= 16'h9C4;
    outletTempRaw <= 16'h7D0;
    clkEn <= 1'h0;
    flow(16'h2);
    clkEn <= 1'h1;
    flow(16'h2);
    check(heatEnergyTotal, 48'hBB8);
    wr(8'h0C, 32'h5, 2'h0);
    for (int k = 0; k < 7; k++) day(0, k == 6);
    check({perfRatio, monthPerfRatio, seasonalPerfRatio}, 24'h0);
    meter.send(3);
    rd(8'h10, 32'h3);
    // Pulse scale x1000 clears history; days carry 1000 heat and 1 or 2 pulses
    wr(8'h00, 32'h30000002, 2'h0);
    for (int k = 0; k < 6; k++) begin
      day(1 + k % 2, k == 5);
      if (k == 4) check(perfRatio, 8'h0);
    end
    check(perfRatio, 8'h6);
    check({monthPerfRatio, seasonalPerfRatio}, 16'h0707);
    wr(8'h00, 32'h2, 2'h0);
    check({perfRatio, monthPerfRatio, seasonalPerfRatio}, 24'h0);
    for (int k = 0; k < 6; k++) day(1, 1'h0);
    check(perfRatio, 8'hC7);
    wr(8'h10, 32'h0, 2'h0);
    check(perfRatio, 8'h0);
    wr(8'h00, 32'h102, 2'h0);
    rd(8'h28, 32'h07D009C4);
    wr(8'h04, 32'h14, 2'h0);
    rd(8'h28, 32'h07E409D8);
    wr(8'h24, 32'h1388, 2'h0);
    wr(8'h00, 32'h20102, 2'h0);
    rd(8'h28, 32'h138809D8);
    wr(8'h04, 32'h64, 2'h0);
    rd(8'h04, 32'h14);
    wr(8'h00, 32'h2, 2'h0);
    rd(8'h04, 32'h0);
    giveVerdict();
  end
endmodule : tb_top
